/* src/modem_line_status_register.sv */
// Modem line status register with loopback, change flags and interrupt logic
`include "modem_status_consts.svh"

//
// How it works
// - bit7 inverted presence pin, loopback aux_b
// - bit6 inverted bell pin, loopback aux_a
// - bit5 inverted peer ready, loopback local ready
// - bit4 inverted send permit, loopback request send
// - bit3 flags any presence level change
// - bit2 flags bell pin rising edge
// - reading status clears all four flags
// - any set change flag raises request
// - read-only status at offset 0x6
// - bit1 flags peer ready pin rising edge
// - bit0 flags any send permit change
module modem_line_status_register
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port
  input wire modem_status_pkg::addr_t addr_i,
  input wire modem_status_pkg::byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output modem_status_pkg::byte_t rdata_o,
  // Active-low modem inputs from the pins
  input wire logic line_presence_in_n_i,
  input wire logic bell_signal_in_n_i,
  input wire logic peer_ready_in_n_i,
  input wire logic clear_to_send_in_n_i,
  // Active-low modem control outputs to the pins
  output logic local_ready_out_n_o,
  output logic request_to_send_out_n_o,
  output logic aux_out_a_n_o,
  output logic aux_out_b_n_o,
  // Interrupts
  output logic modem_irq_req_o,
  output logic irq_o
);

  import modem_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  nibble_t pins_async;
  nibble_t pins_sync;

  // Pin order matches status bits 7 down to 4
  assign pins_async = {line_presence_in_n_i, bell_signal_in_n_i,
                       peer_ready_in_n_i, clear_to_send_in_n_i};

  sync_2ff #(
    .W(4),
    .RESET_VAL(`PIN_IDLE)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arming counter

  // Edges are ignored until the synchroniser holds real pin samples,
  // so a pin held low through reset does not look like a change
  logic [1:0] arm_count;
  logic [1:0] next_arm_count;
  logic armed;

  always_comb
  begin
    next_arm_count = arm_count;
    if (arm_count != `ARM_CYCLES)
    begin
      next_arm_count = arm_count + `ARM_STEP;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      arm_count <= `ARM_ZERO;
    end
    else
    begin
      arm_count <= next_arm_count;
    end
  end

  assign armed = (arm_count == `ARM_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  reg_sel_t sel;
  logic rd_status;
  logic wr_ctrl;
  logic wr_irq_status;
  logic wr_irq_mask;

  assign sel = decode(addr_i);
  assign rd_status = rd_i && (sel == sel_status);
  assign wr_ctrl = wr_i && (sel == sel_ctrl);
  assign wr_irq_status = wr_i && (sel == sel_irq_status);
  assign wr_irq_mask = wr_i && (sel == sel_irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [`CTRL_USED_W-1:0] ctrl;
  logic [`CTRL_USED_W-1:0] next_ctrl;
  logic loopback;

  // Control bits in status bit order: aux_b, aux_a, local ready, request
  function automatic nibble_t ctrl_levels(input logic [`CTRL_USED_W-1:0] c);
    return {c[`CTRL_AUX_B], c[`CTRL_AUX_A], c[`CTRL_LOCAL_READY], c[`CTRL_REQ_SEND]};
  endfunction

  // Software writes the modem control bits and the loopback switch
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
    begin
      next_ctrl = wdata_i[`CTRL_USED_W-1:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= `CTRL_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  assign loopback = ctrl[`CTRL_LOOPBACK];

  ////////////////////////////////////////////////////////////////////////////
  // Modem control outputs

  nibble_t out_n;
  nibble_t next_out_n;

  // Parked inactive (high) in loopback so the modem sees no activity while
  // the looped values stay internal; taken from the next control value so
  // the pins still move at the same edge as the control register
  always_comb
  begin
    next_out_n = `OUT_N_IDLE;
    if (!next_ctrl[`CTRL_LOOPBACK])
    begin
      next_out_n = ~ctrl_levels(next_ctrl);
    end
  end

  // Registered so the pins never glitch while software rewrites control
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      out_n <= `OUT_N_IDLE;
    end
    else
    begin
      out_n <= next_out_n;
    end
  end

  // Pin order matches the status bit order of the looped levels
  assign {aux_out_b_n_o, aux_out_a_n_o,
          local_ready_out_n_o, request_to_send_out_n_o} = out_n;

  ////////////////////////////////////////////////////////////////////////////
  // Live status levels

  nibble_t live;
  nibble_t looped;

  // Looped control values in status bit order
  assign looped = ctrl_levels(ctrl);

  // One status level: the looped control bit, or the inverse of its pin
  function automatic logic pick_level(
    input logic loop_on,
    input logic looped_bit,
    input logic pin_n
  );
    return loop_on ? looped_bit : ~pin_n;
  endfunction

  // Select pin or looped source for each status bit
  always_comb
  begin
    live[3] = pick_level(loopback, looped[3], pins_sync[3]);
    live[2] = pick_level(loopback, looped[2], pins_sync[2]);
    // peer ready from pin or local ready
    live[1] = pick_level(loopback, looped[1], pins_sync[1]);
    // send permit from pin or request
    live[0] = pick_level(loopback, looped[0], pins_sync[0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change flags

  nibble_t flags;
  nibble_t flag_events;

  // change detectors fed from live levels
  // bell edge detected in flag module
  // peer ready edge detected in flag module
  // send permit change detected in flag module
  // loopback feeds looped values to detectors
  modem_change_flags u_flags (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(live),
    .armed_i(armed),
    .clear_i(rd_status),
    .flags_o(flags),
    .events_o(flag_events)
  );

  assign modem_irq_req_o = |flags;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  nibble_t irq_status;
  nibble_t next_irq_status;
  nibble_t irq_mask;
  nibble_t next_irq_mask;
  nibble_t w1c;

  assign w1c = wr_irq_status ? wdata_i[3:0] : `IRQ_STATUS_RESET;

  // Sticky bits, one per change flag; a new event wins over a clear
  always_comb
  begin
    next_irq_status = (irq_status & ~w1c) | flag_events;
    next_irq_mask = irq_mask;
    if (wr_irq_mask)
    begin
      next_irq_mask = wdata_i[3:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      irq_status <= `IRQ_STATUS_RESET;
      irq_mask <= `IRQ_MASK_RESET;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // Level output, high while an unmasked sticky bit is set
  assign irq_o = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  byte_t next_rdata;

  // Data show in the cycle after the read strobe and only there
  always_comb
  begin
    next_rdata = `RDATA_RESET;
    if (rd_i)
    begin
      unique case (sel)
        sel_status: next_rdata = {live, flags};
        sel_ctrl: next_rdata = {{(8-`CTRL_USED_W){1'b0}}, ctrl};
        sel_irq_status: next_rdata = {4'h0, irq_status};
        sel_irq_mask: next_rdata = {4'h0, irq_mask};
        sel_none: next_rdata = `UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= `RDATA_RESET;
    end
    else
    begin
      rdata_o <= next_rdata;
    end
  end

endmodule

/* shared/modem_status_consts.svh */
// Offsets, bit positions, reset values and counts of the modem line status block
`ifndef MODEM_STATUS_CONSTS_SVH
`define MODEM_STATUS_CONSTS_SVH

// Register port address width
`define ADDR_W 4

// Register offsets
`define OFF_LINE_STATUS 4'h6
`define OFF_CTRL 4'h8
`define OFF_IRQ_STATUS 4'h9
`define OFF_IRQ_MASK 4'ha

// Status register bit positions
`define BIT_PRESENCE 7
`define BIT_BELL 6
`define BIT_PEER_READY 5
`define BIT_SEND_PERMIT 4
`define BIT_PRESENCE_CHG 3
`define BIT_BELL_CHG 2
`define BIT_PEER_CHG 1
`define BIT_SEND_CHG 0

// Control register bit positions
`define CTRL_LOCAL_READY 0
`define CTRL_REQ_SEND 1
`define CTRL_AUX_A 2
`define CTRL_AUX_B 3
`define CTRL_LOOPBACK 4
`define CTRL_USED_W 5

// Reset values
`define CTRL_RESET 5'h00
`define IRQ_STATUS_RESET 4'h0
`define IRQ_MASK_RESET 4'h0
`define FLAGS_RESET 4'h0
`define LEVEL_RESET 4'h0
`define PIN_IDLE 4'hf
`define OUT_N_IDLE 4'hf
`define RDATA_RESET 8'h00
`define UNMAPPED_READ 8'h00

// Cycles after reset before edges are believed
`define ARM_CYCLES 2'd3
`define ARM_ZERO 2'd0
`define ARM_STEP 2'd1

`endif

/* shared/modem_status_pkg.sv */
// Types and decode helper shared by the modem line status block
package modem_status_pkg;
  `include "modem_status_consts.svh"

  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] nibble_t;

  // Register selected by an address
  typedef enum {sel_none, sel_status, sel_ctrl, sel_irq_status, sel_irq_mask} reg_sel_t;

  // Address decode shared by the read and write paths
  function automatic reg_sel_t decode(input addr_t addr);
    reg_sel_t sel;
    sel = sel_none;
    unique case (addr)
      `OFF_LINE_STATUS: sel = sel_status;
      `OFF_CTRL: sel = sel_ctrl;
      `OFF_IRQ_STATUS: sel = sel_irq_status;
      `OFF_IRQ_MASK: sel = sel_irq_mask;
      default: sel = sel_none;
    endcase
    return sel;
  endfunction
endpackage

/* src/sync_2ff.sv */
// Two flip-flop synchroniser for a group of asynchronous levels
module sync_2ff #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  // First stage feeds only the second stage
  always_comb
  begin
    next_stage1 = async_i;
    next_sync = stage1;
  end

  // Both stages reset to the idle pin level
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= RESET_VAL;
      sync_o <= RESET_VAL;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_o <= next_sync;
    end
  end

endmodule

/* src/modem_change_flags.sv */
// Change flags of the four modem status levels, cleared by a status read
`include "modem_status_consts.svh"

module modem_change_flags
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire modem_status_pkg::nibble_t level_i,
  input wire logic armed_i,
  input wire logic clear_i,
  output modem_status_pkg::nibble_t flags_o,
  output modem_status_pkg::nibble_t events_o
);

  import modem_status_pkg::*;

  // Level order: 3 presence, 2 bell, 1 peer ready, 0 send permit
  nibble_t prev;
  nibble_t next_prev;
  nibble_t next_flags;
  nibble_t fell;

  // Edge detect and flag update; a new edge beats the clearing read
  always_comb
  begin
    next_prev = level_i;
    fell = prev & ~level_i;
    events_o = '0;
    if (armed_i)
    begin
      events_o[3] = prev[3] ^ level_i[3];
      // Pin rising means status bit falling
      events_o[2] = fell[2];
      events_o[1] = fell[1];
      events_o[0] = prev[0] ^ level_i[0];
    end
    next_flags = (clear_i ? `FLAGS_RESET : flags_o) | events_o;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      prev <= `LEVEL_RESET;
      flags_o <= `FLAGS_RESET;
    end
    else
    begin
      prev <= next_prev;
      flags_o <= next_flags;
    end
  end

endmodule

/* sim/modem_line_status_register_props.sv */
// Checker of the modem line status register port behaviour
module modem_line_status_register_props
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire modem_status_pkg::addr_t addr_i,
  input wire modem_status_pkg::byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire modem_status_pkg::byte_t rdata_o,
  input wire logic line_presence_in_n_i,
  input wire logic bell_signal_in_n_i,
  input wire logic peer_ready_in_n_i,
  input wire logic clear_to_send_in_n_i,
  input wire logic local_ready_out_n_o,
  input wire logic request_to_send_out_n_o,
  input wire logic aux_out_a_n_o,
  input wire logic aux_out_b_n_o,
  input wire logic modem_irq_req_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import modem_status_pkg::*;
  logic lb;
  logic next_lb;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Loopback copy, since pins are ignored while it is set
  always_comb next_lb = (wr_i && addr_i == 4'h8) ? wdata_i[4] : lb;
  always_ff @(posedge mclk_i) lb <= rst_n_i ? next_lb : 1'b0;
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (rd_i && addr_i == 4'h0 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_flags_report: assert property (rd_i && addr_i == 4'h6 |=>
    (|rdata_o[3:0]) == $past(modem_irq_req_o)) else $error("request differs from flags");
  a_clear_by_read: assert property ($fell(modem_irq_req_o) |->
    $past(rd_i) && $past(addr_i) == 4'h6) else $error("flags dropped without read");
  a_irq_cause: assert property ($rose(irq_o) |-> modem_irq_req_o || $past(wr_i))
    else $error("interrupt without cause");
  a_presence_flag: assert property (!lb && $changed(line_presence_in_n_i) |->
    ##[1:3] modem_irq_req_o) else $error("presence change not flagged");
  a_bell_flag: assert property (!lb && $rose(bell_signal_in_n_i) |->
    ##[1:3] modem_irq_req_o) else $error("bell edge not flagged");
  a_peer_flag: assert property (!lb && $rose(peer_ready_in_n_i) |->
    ##[1:3] modem_irq_req_o) else $error("peer edge not flagged");
  a_cts_flag: assert property (!lb && $changed(clear_to_send_in_n_i) |->
    ##[1:3] modem_irq_req_o) else $error("send permit change not flagged");
  a_loop_parked: assert property (wr_i && addr_i == 4'h8 && wdata_i[4] |=>
    &{aux_out_b_n_o, aux_out_a_n_o, request_to_send_out_n_o, local_ready_out_n_o})
    else $error("outputs not parked in loopback");
  cover property (rd_i && addr_i == 4'h6 && modem_irq_req_o);
  cover property ($rose(irq_o));
  cover property (lb && rd_i);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind modem_line_status_register modem_line_status_register_props props_u (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .line_presence_in_n_i(line_presence_in_n_i),
  .bell_signal_in_n_i(bell_signal_in_n_i), .peer_ready_in_n_i(peer_ready_in_n_i),
  .clear_to_send_in_n_i(clear_to_send_in_n_i), .local_ready_out_n_o(local_ready_out_n_o),
  .request_to_send_out_n_o(request_to_send_out_n_o), .aux_out_a_n_o(aux_out_a_n_o),
  .aux_out_b_n_o(aux_out_b_n_o), .modem_irq_req_o(modem_irq_req_o), .irq_o(irq_o));

/* sim/modem_peer_model.sv */
// Modem side model driving the four active-low status lines
module modem_peer_model (
  output logic line_presence_in_n_o,
  output logic bell_signal_in_n_o,
  output logic peer_ready_in_n_o,
  output logic clear_to_send_in_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] asserted = 4'h0;
  // Lines idle high; a set bit pulls its line low
  assign {line_presence_in_n_o, bell_signal_in_n_o, peer_ready_in_n_o,
    clear_to_send_in_n_o} = ~asserted;
  task automatic set_lines(input logic [3:0] v);
    asserted <= v;
  endtask
endmodule

/* sim/modem_line_status_register_tb.sv */
// Testbench of the modem line status register
module modem_line_status_register_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import modem_status_pkg::*;
  logic mclk_i;
  logic rst_n_i;
  addr_t addr_i;
  byte_t wdata_i;
  logic wr_i;
  logic rd_i;
  byte_t rdata_o;
  wire logic lp_n, bl_n, pr_n, cs_n;
  logic lr_n, rs_n, xa_n, xb_n, mreq, irq;
  wire logic [3:0] outs = {xb_n, xa_n, rs_n, lr_n};
  int miscompares;
  int checks;
  modem_line_status_register dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .line_presence_in_n_i(lp_n), .bell_signal_in_n_i(bl_n), .peer_ready_in_n_i(pr_n),
    .clear_to_send_in_n_i(cs_n), .local_ready_out_n_o(lr_n), .request_to_send_out_n_o(rs_n),
    .aux_out_a_n_o(xa_n), .aux_out_b_n_o(xb_n), .modem_irq_req_o(mreq), .irq_o(irq));
  modem_peer_model peer_u (.line_presence_in_n_o(lp_n), .bell_signal_in_n_o(bl_n),
    .peer_ready_in_n_o(pr_n), .clear_to_send_in_n_o(cs_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 25 ns
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input byte_t got, input byte_t exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input addr_t a, input byte_t d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Data is looked at only in the one cycle it stands
  task automatic rd(input addr_t a, input byte_t exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic lines(input logic [3:0] v);
    @(posedge mclk_i);
    peer_u.set_lines(v);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short; the tests need well under 1000 cycles
  initial
  begin
    #50000;
    miscompares++;
    conclude();
  end
  initial
  begin
    miscompares = 0;
    checks = 0;
    rst_n_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(4'h6, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'h9, 8'h00);
    rd(4'ha, 8'h00);
    rd(4'h0, 8'h00);
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h00);
    $display("test 1 done");
    lines(4'hf);
    repeat (4) @(posedge mclk_i);
    rd(4'h6, 8'hf9);
    rd(4'h6, 8'hf0);
    chk({7'h0, mreq}, 8'h00);
    chk({7'h0, irq}, 8'h00);
    lines(4'h0);
    repeat (4) @(posedge mclk_i);
    rd(4'h6, 8'h0f);
    $display("test 2 done");
    rd(4'h9, 8'h0f);
    wr(4'ha, 8'h01);
    @(posedge mclk_i);
    chk({7'h0, irq}, 8'h01);
    wr(4'h9, 8'h0f);
    @(posedge mclk_i);
    chk({7'h0, irq}, 8'h00);
    rd(4'h9, 8'h00);
    $display("test 3 done");
    wr(4'h8, 8'h1f);
    lines(4'hf);
    repeat (3) @(posedge mclk_i);
    chk({4'h0, outs}, 8'h0f);
    rd(4'h6, 8'hf9);
    wr(4'h8, 8'h10);
    repeat (3) @(posedge mclk_i);
    rd(4'h6, 8'h0f);
    lines(4'h0);
    wr(4'h8, 8'h00);
    repeat (4) @(posedge mclk_i);
    rd(4'h6, 8'h00);
    chk({4'h0, outs}, 8'h0f);
    wr(4'h8, 8'h0f);
    @(posedge mclk_i);
    chk({4'h0, outs}, 8'h00);
    wr(4'h8, 8'h05);
    @(posedge mclk_i);
    chk({4'h0, outs}, 8'h0a);
    $display("test 4 done");
    lines(4'h1);
    @(posedge mclk_i);
    rd(4'h6, 8'h10);
    chk({7'h0, mreq}, 8'h01);
    rd(4'h6, 8'h11);
    $display("test 5 done");
    conclude();
  end
endmodule
